// ===== verilog/vcrc_map.vh
// register offsets, field positions and reset values of the channel resource 0 bank
`ifndef VCRC_MAP_VH
`define VCRC_MAP_VH

// ----------------------------------------------------------------------------
// byte addresses
// ----------------------------------------------------------------------------
`define VCRC_ADDR_W          12
`define VCRC_OFF_CAP         12'h210
`define VCRC_OFF_CTL         12'h214

// ----------------------------------------------------------------------------
// capability word fields
// ----------------------------------------------------------------------------
`define VCRC_CAP_ARB_HI      7
`define VCRC_CAP_ARB_LO      0
`define VCRC_CAP_APS_BIT     14
`define VCRC_CAP_RJS_BIT     15
`define VCRC_CAP_MTS_HI      22
`define VCRC_CAP_MTS_LO      16
`define VCRC_CAP_TOF_HI      31
`define VCRC_CAP_TOF_LO      24

// arbitration scheme bits
`define VCRC_ARB_FIXED_RR    8'h01
`define VCRC_ARB_WRR32       8'h02
`define VCRC_ARB_WRR64       8'h04
`define VCRC_ARB_WRR128      8'h08
`define VCRC_ARB_TBWRR128    8'h10
`define VCRC_ARB_WRR256      8'h20

`define VCRC_TOF_UP          8'h02
`define VCRC_TOF_DOWN        8'h00
`define VCRC_MTS_VALUE       7'h00

// ----------------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------------
`define VCRC_CTL_MAP_HI      7
`define VCRC_CTL_MAP_LO      0
`define VCRC_MAP_RESET       8'hff
`define VCRC_MAP_WR_MASK     8'hfe

`endif

// ===== verilog/vcrc_cap_rom.v
// capability word builder, registered, chosen by port role
`include "vcrc_map.vh"
`default_nettype none

module vcrc_cap_rom (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        is_upstream,
    output reg  [31:0] cap_word_q
);

    // ------------------------------------------------------------------------
    // field values
    // ------------------------------------------------------------------------
    // several schemes are reported at once by or-ing their bits
    wire [7:0] arb_up   = `VCRC_ARB_FIXED_RR | `VCRC_ARB_WRR32;
    wire [7:0] arb_down = `VCRC_ARB_FIXED_RR;
    reg  [31:0] cap_d;

    always @* begin
        cap_d = 32'h0000_0000;
        cap_d[`VCRC_CAP_ARB_HI:`VCRC_CAP_ARB_LO] = is_upstream ? arb_up : arb_down;
        cap_d[`VCRC_CAP_APS_BIT] = 1'b0;
        cap_d[`VCRC_CAP_RJS_BIT] = 1'b0;
        cap_d[`VCRC_CAP_MTS_HI:`VCRC_CAP_MTS_LO] = `VCRC_MTS_VALUE;
        // zero offset tells software no table exists downstream
        cap_d[`VCRC_CAP_TOF_HI:`VCRC_CAP_TOF_LO] =
            is_upstream ? `VCRC_TOF_UP : `VCRC_TOF_DOWN;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_word_q <= 32'h0000_0000;
        end else begin
            cap_word_q <= cap_d;
        end
    end

endmodule // vcrc_cap_rom

`default_nettype wire

// ===== verilog/vcrc_regs.v
// channel resource 0 capability and control registers behind an Avalon-MM slave
//
// What this block does
// - capability bits 7:0 read 0x3 upstream, 0x1 downstream, read-only; a read on the first clock after reset sees zero
// - each capability bit names one arbitration scheme, bit 0 to bit 5
// - all supported schemes are reported together, not just one
// - advanced packet switching bit 14 always reads zero
// - snoop rejection bit 15 always reads zero
// - maximum time slots bits 22:16 read zero
// - table offset bits 31:24 read 0x2 upstream, 0x0 downstream; a read on the first clock after reset sees zero
// - only the upstream port has an arbitration table
// - traffic class map resets to 0xff, bit n maps class n here
// - map bit 0 is read-only, bits 1 to 7 are writable
//
// Our own choice: the Avalon-MM interface to the registers.
`include "vcrc_map.vh"
`default_nettype none

module vcrc_regs #(
    parameter UPSTREAM_PORT = 1
) (
    input  wire        CORE_CLK,
    input  wire        RST_N,
    input  wire [11:0] AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    input  wire [3:0]  AVS_BYTEENABLE,
    output reg  [31:0] AVS_READDATA,
    output reg         AVS_WAITREQUEST,
    output reg  [1:0]  AVS_RESPONSE,
    output reg  [7:0]  TRAFFIC_CLASS_MAP
);

    // ------------------------------------------------------------------------
    // local definitions
    // ------------------------------------------------------------------------
    localparam [1:0] RESP_OKAY   = 2'h0;
    localparam [1:0] RESP_DECERR = 2'h3;

    // one-hot handshake states: idle waits a cycle, ack drops waitrequest
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ACK  = 2'b10;

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [7:0]  map_q;
    reg  [7:0]  map_d;
    wire [31:0] cap_word;
    wire        is_upstream = (UPSTREAM_PORT != 0);

    function [1:0] addr_hit;
        input [11:0] addr;
        begin
            addr_hit = {addr == `VCRC_OFF_CTL, addr == `VCRC_OFF_CAP};
        end
    endfunction

    wire [1:0] hit = addr_hit(AVS_ADDRESS);
    wire       req = AVS_READ | AVS_WRITE;

    // ------------------------------------------------------------------------
    // capability word
    // ------------------------------------------------------------------------
    vcrc_cap_rom u_cap (
        .clk         (CORE_CLK),
        .rst_n       (RST_N),
        .is_upstream (is_upstream),
        .cap_word_q  (cap_word)
    );

    // ------------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------------
    // waitrequest is high at rest; a request is answered one cycle later, so
    // the decoded read data are registered before the master samples them
    always @* begin
        case (state_q)
            ST_IDLE: state_d = req ? ST_ACK : ST_IDLE;
            ST_ACK:  state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    wire accept = (state_q == ST_IDLE) && req;

    // ------------------------------------------------------------------------
    // traffic class map
    // ------------------------------------------------------------------------
    always @* begin
        map_d = map_q;
        if (accept && AVS_WRITE && hit[1] && AVS_BYTEENABLE[0]) begin
            // bit 0 keeps its value; class 0 always rides on this channel
            map_d = (map_q & ~`VCRC_MAP_WR_MASK) |
                    (AVS_WRITEDATA[`VCRC_CTL_MAP_HI:`VCRC_CTL_MAP_LO] &
                     `VCRC_MAP_WR_MASK);
        end
    end

    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q           <= ST_IDLE;
            map_q             <= `VCRC_MAP_RESET;
            TRAFFIC_CLASS_MAP <= `VCRC_MAP_RESET;
            AVS_WAITREQUEST   <= 1'b1;
            AVS_READDATA      <= 32'h0000_0000;
            AVS_RESPONSE      <= RESP_OKAY;
        end else begin
            state_q           <= state_d;
            map_q             <= map_d;
            TRAFFIC_CLASS_MAP <= map_d;
            AVS_WAITREQUEST   <= ~accept;
            if (accept) begin
                AVS_RESPONSE <= (hit == 2'b00) ? RESP_DECERR : RESP_OKAY;
                if (AVS_READ) begin
                    // upper control bits are outside this bank and read zero
                    AVS_READDATA <= hit[0] ? cap_word :
                                    hit[1] ? {24'h00_0000, map_q} : 32'h0000_0000;
                end else begin
                    AVS_READDATA <= 32'h0000_0000;
                end
            end
        end
    end

    // the select field is checked by software against the capability bits;
    // this bank does not police it

endmodule // vcrc_regs

`default_nettype wire

// ===== tb/vcrc_regs_sva.sv
// assertion checker for the channel resource 0 register bank
`default_nettype none
module vcrc_regs_sva #(parameter UPSTREAM_PORT = 1) (
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic [11:0] AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic [1:0]  AVS_RESPONSE,
    input wire logic [7:0]  TRAFFIC_CLASS_MAP
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wd_q;
    always_ff @(posedge CORE_CLK) wd_q <= AVS_WRITEDATA[7:0];
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_take; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST; endsequence
    sequence s_cap; s_take ##0 AVS_READ && AVS_ADDRESS == 12'h210; endsequence
    sequence s_wr; s_take ##0 AVS_WRITE && AVS_ADDRESS == 12'h214 && AVS_BYTEENABLE[0]; endsequence
    sequence s_bad; s_take ##0 AVS_ADDRESS != 12'h210 && AVS_ADDRESS != 12'h214; endsequence
    AST_ACK: assert property (s_take |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("ack");
    AST_CAP_ARB: assert property (s_cap |=> AVS_READDATA[7:0] == (UPSTREAM_PORT ? 8'h03 : 8'h01))
        else $error("arb");
    AST_CAP_FIX: assert property (s_cap |=> AVS_READDATA[23:8] == 16'h0) else $error("fix");
    AST_CAP_TOF: assert property (s_cap |=> AVS_READDATA[31:24] == (UPSTREAM_PORT ? 8'h02 : 8'h00))
        else $error("tof");
    AST_MAP_B0: assert property (TRAFFIC_CLASS_MAP[0]) else $error("bit0");
    AST_MAP_WR: assert property (s_wr |=> TRAFFIC_CLASS_MAP == {wd_q[7:1], 1'h1}) else $error("wr");
    AST_MAP_KEEP: assert property (!(AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == 12'h214
        && AVS_BYTEENABLE[0]) |=> $stable(TRAFFIC_CLASS_MAP)) else $error("keep");
    AST_DEC_ERR: assert property (s_bad |=> AVS_RESPONSE == 2'h3) else $error("dec");
endmodule // vcrc_regs_sva
`default_nettype wire

// ===== tb/vcrc_regs_tb.sv
// self-checking bench for the channel resource 0 register bank
`default_nettype none
module vcrc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [3:0] b; logic [31:0] e;} vcrc_row_t;
    logic        CORE_CLK = 1'h0, RST_N = 1'h0, AVS_READ = 1'h0, AVS_WRITE = 1'h0, AVS_WAITREQUEST;
    logic [11:0] AVS_ADDRESS = 12'h0;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd_d, rd_q, rdd_q;
    logic [3:0]  AVS_BYTEENABLE = 4'h0;
    logic [1:0]  AVS_RESPONSE, rsp_q;
    logic [7:0]  TRAFFIC_CLASS_MAP;
    int          bad_count = 0, checks_done = 0;
    vcrc_row_t   rows [8] = '{
        '{1'h0, 12'h214, 32'h0, 4'hf, 32'hff}, '{1'h0, 12'h210, 32'h0, 4'hf, 32'h02000003},
        '{1'h1, 12'h214, 32'h0, 4'hf, 32'h01}, '{1'h1, 12'h214, 32'hff01ff5a, 4'hf, 32'h5b},
        '{1'h1, 12'h214, 32'ha4, 4'he, 32'h5b}, '{1'h1, 12'h210, 32'h0, 4'hf, 32'h5b},
        '{1'h0, 12'h214, 32'h0, 4'hf, 32'h5b}, '{1'h1, 12'h21c, 32'hff, 4'hf, 32'h5b}};
    always #2 CORE_CLK = ~CORE_CLK;
    vcrc_regs dut_u (.CORE_CLK, .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
        .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .AVS_RESPONSE, .TRAFFIC_CLASS_MAP);
    // downstream copy shares the bus; the bench watches only its read data, the bound checker all its ports
    vcrc_regs #(.UPSTREAM_PORT(0)) dut_d (.CORE_CLK, .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
        .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA(rd_d), .AVS_WAITREQUEST(),
        .AVS_RESPONSE(), .TRAFFIC_CLASS_MAP());
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        AVS_READ <= !w;
        AVS_WRITE <= w;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= b;
        @(posedge CORE_CLK);
        while (AVS_WAITREQUEST !== 1'h0 && n < 16) begin
            @(posedge CORE_CLK);
            n++;
        end
        if (n == 16) begin
            chk(32'h1, 32'h0);
            test_done();
        end
        rd_q = AVS_READDATA;
        rdd_q = rd_d;
        rsp_q = AVS_RESPONSE;
        AVS_READ <= 1'h0;
        AVS_WRITE <= 1'h0;
        @(posedge CORE_CLK);
    endtask
    initial begin
        repeat (8) @(posedge CORE_CLK);
        RST_N <= 1'h1;
        @(posedge CORE_CLK);
        foreach (rows[i]) begin
            acc(rows[i].w, rows[i].a, rows[i].d, rows[i].b);
            chk(rows[i].w ? {24'h0, TRAFFIC_CLASS_MAP} : rd_q, rows[i].e);
            chk({30'h0, rsp_q}, (rows[i].a == 12'h210 || rows[i].a == 12'h214) ? 32'h0 : 32'h3);
            $display("row %0d done", i);
        end
        acc(1'h0, 12'h210, 32'h0, 4'hf);
        chk(rdd_q, 32'h00000001);
        $display("downstream done");
        // reset mid-run must bring the map back even after writes
        RST_N <= 1'h0;
        @(posedge CORE_CLK);
        chk({24'h0, TRAFFIC_CLASS_MAP}, 32'hff);
        RST_N <= 1'h1;
        @(posedge CORE_CLK);
        acc(1'h0, 12'h214, 32'h0, 4'hf);
        chk(rd_q, 32'hff);
        $display("reset done");
        test_done();
    end
endmodule // vcrc_regs_tb
bind vcrc_regs vcrc_regs_sva #(.UPSTREAM_PORT(UPSTREAM_PORT)) chk_u (.CORE_CLK, .RST_N,
    .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
    .AVS_WAITREQUEST, .AVS_RESPONSE, .TRAFFIC_CLASS_MAP);
`default_nettype wire
